// [tfh_target_core.sv]
// Target-side handshake of the embedded PCI core towards user fabric logic
// What this block does
// - Drive last low on final address portion
// - Last with the first portion reuses previous address
// - Drive last low with final write word
// - Last only counts on a word's final cycle
// - Burst pending low: wait states, then disconnect
// - Data enable low captures fabric data each edge unless the read FIFO is full
// - Full flag low when no room remains
// - Almost-full low at four free locations
// - Empty flag low when read FIFO empty
// - Read hold delays PCI transfer until release/full
// - Read last low marks final read data
// - Request stays active while addresses pending
`timescale 1ns/10ps
`default_nettype none
`include "tfh_regs.svh"
module tfh_target_core import tfh_pkg::*; #(
    parameter int DW = `TFH_FIFO_WIDTH,
    parameter int DEPTH = `TFH_FIFO_DEPTH,
    parameter int MAX_WAIT = `TFH_MAX_WAIT
) (
    input wire logic hclk, // Bus, FIFO and PCI clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    output logic [31:0] hrdata, // AHB read data
    output logic irq, // Level interrupt
    input wire logic pci_addr_valid, // PCI side offers address
    input wire logic [63:0] pci_addr, // PCI address
    input wire logic pci_addr_reuse, // Reuse previous address
    output logic pci_addr_ready, // Address slot free
    input wire logic pci_wr_valid, // PCI write word offered
    input wire logic [DW-1:0] pci_wr_data, // PCI write word
    input wire logic pci_wr_final, // Word ends the operation
    output logic pci_wr_ready, // Write slot free
    output logic pci_wr_disconnect, // Disconnect pulse
    input wire logic pci_rd_req, // Burst read in progress
    input wire logic pci_rd_final, // PCI needs no more data
    input wire logic pci_rd_take, // PCI takes head word
    output logic pci_rd_valid, // Head word may go to PCI
    output logic [DW-1:0] pci_rd_data, // Head word
    output logic target_req_n, // Request pending, low
    input wire logic addr_en_n, // Address portion enable, low
    input wire logic wr_data_en_n, // Write data enable, low
    output logic [DW-1:0] data_to_fabric, // Address or write data
    output logic tw_last_n, // Last address/write cycle, low
    output logic wr_empty_n, // Write slot empty, low
    input wire logic burst_pend_n, // Burst pending, low
    input wire logic [DW-1:0] data_fm_fabric, // Read data from fabric
    input wire logic rd_data_en_n, // Read data enable, low
    output logic rd_fifo_full_n, // Read FIFO full, low
    output logic rd_fifo_almost_full_n, // Four free left, low
    output logic rd_fifo_empty_n, // Read FIFO empty, low
    input wire logic rd_hold_n, // Hold PCI read start, low
    output logic rd_last_n // Last read data, low
);
    localparam int CW = $clog2(DEPTH+1);

    // Narrow mode splits a 64-bit word into two 32-bit halves
    generate
        if (DW != 64 || MAX_WAIT < 1 || MAX_WAIT > 255) begin : g_chk
            $error("tfh_target_core: DW must be 64 and MAX_WAIT 1..255");
        end
    endgenerate

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    tfh_ahb_type ap; // Captured address phase
    logic narrow; // Control: 32-bit fabric transfers
    logic [`TFH_IRQ_W-1:0] irq_stat; // Sticky events
    logic [`TFH_IRQ_W-1:0] irq_mask; // Interrupt enables
    logic [`TFH_IRQ_W-1:0] irq_ev; // Events this cycle
    logic [`TFH_IRQ_W-1:0] irq_clr; // Write-one-to-clear
    logic addr_pending; // Address slot holds an entry
    logic addr_reuse; // Entry asks to reuse previous address
    logic [63:0] cur_addr; // Pending address
    logic [63:0] last_addr; // Previously transferred address
    logic addr_part; // High half of address sent next
    logic addr_take; // Address portion taken this edge
    logic addr_final; // Portion being taken is the last
    logic wr_full; // Write slot holds a word
    logic wr_fin; // Held word ends the operation
    logic [DW-1:0] wr_word; // Held write word
    logic wr_part; // High half of write word next
    logic wr_take; // Write cycle taken this edge
    logic wr_last_cyc; // Write cycle being taken ends the word
    tfh_wstate_type wstate; // Wait-state controller
    logic [7:0] wait_cnt; // Wait states inserted so far
    logic rd_half; // Low half of read word stored
    logic [31:0] rd_lo; // Stored low half
    logic rd_push; // Push into read FIFO
    logic [DW-1:0] rd_din; // Word pushed
    logic rd_started; // PCI read transfer released
    tfh_flags_type rd_flags; // Read FIFO flags
    logic [CW-1:0] rd_count; // Read FIFO level
    logic [31:0] next_rdata; // Read mux
    logic [31:0] status; // Live status word

    // Zero-wait slave; every answer is OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap <= '0;
        end else if (hready) begin
            ap.valid <= hsel && htrans[1];
            ap.write <= hwrite;
            ap.addr <= haddr[7:0];
        end
    end

    // Status word built from live state
    assign status = {19'h0, wstate, rd_started, target_req_n, rd_flags.empty_n,
                     rd_flags.afull_n, rd_flags.full_n, rd_count};

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = 32'h0;
        if (haddr[7:0] == `TFH_CTRL_OFS) begin
            next_rdata = {31'h0, narrow};
        end else if (haddr[7:0] == `TFH_STATUS_OFS) begin
            next_rdata = status;
        end else if (haddr[7:0] == `TFH_IRQ_STAT_OFS) begin
            next_rdata = {29'h0, irq_stat};
        end else if (haddr[7:0] == `TFH_IRQ_MASK_OFS) begin
            next_rdata = {29'h0, irq_mask};
        end else if (haddr[7:0] == `TFH_ADDR_LO_OFS) begin
            next_rdata = last_addr[31:0];
        end else if (haddr[7:0] == `TFH_ADDR_HI_OFS) begin
            next_rdata = last_addr[63:32];
        end
    end

    // Read data registered at the address phase, stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Control and mask writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            narrow <= `TFH_CTRL_RST;
            irq_mask <= `TFH_IRQ_RST;
        end else if (ap.valid && ap.write) begin
            if (ap.addr == `TFH_CTRL_OFS) begin
                narrow <= hwdata[`TFH_CTRL_NARROW_BIT];
            end else if (ap.addr == `TFH_IRQ_MASK_OFS) begin
                irq_mask <= hwdata[`TFH_IRQ_W-1:0];
            end
        end
    end

    // Sticky events: a new event wins over a clear in the same cycle
    assign irq_clr = (ap.valid && ap.write && ap.addr == `TFH_IRQ_STAT_OFS)
                     ? hwdata[`TFH_IRQ_W-1:0] : '0;
    assign irq_ev[`TFH_IRQ_OVF_BIT] = !rd_data_en_n && !rd_flags.full_n;
    assign irq_ev[`TFH_IRQ_DISC_BIT] = pci_wr_disconnect;
    assign irq_ev[`TFH_IRQ_ADDR_BIT] = addr_take && addr_final;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= `TFH_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // Address slot: request stays low while an entry waits
    assign pci_addr_ready = !addr_pending;
    assign target_req_n = !addr_pending;
    assign addr_take = !addr_en_n && addr_pending;
    // Reuse, wide mode, upper half sent, or zero upper half all end the address
    assign addr_final = addr_reuse || !narrow || addr_part || (cur_addr[63:32] == 32'h0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_pending <= 1'b0;
            addr_reuse <= 1'b0;
            cur_addr <= 64'h0;
            addr_part <= 1'b0;
        end else if (!addr_pending) begin
            addr_pending <= pci_addr_valid;
            addr_reuse <= pci_addr_reuse;
            cur_addr <= pci_addr;
            addr_part <= 1'b0;
        end else if (addr_take) begin
            addr_pending <= !addr_final;
            addr_part <= !addr_final;
        end
    end

    // Previous address kept so that a reuse entry needs no new portion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_addr <= 64'h0;
        end else if (addr_take && addr_final && !addr_reuse) begin
            last_addr <= cur_addr;
        end
    end

    // Write slot; address portions take priority on the shared bus
    assign wr_take = !wr_data_en_n && wr_full && !addr_take;
    assign wr_last_cyc = !narrow || wr_part;
    assign wr_empty_n = wr_full;
    assign pci_wr_ready = !wr_full;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_full <= 1'b0;
            wr_fin <= 1'b0;
            wr_word <= '0;
            wr_part <= 1'b0;
        end else if (!wr_full) begin
            wr_full <= pci_wr_valid;
            wr_fin <= pci_wr_final;
            wr_word <= pci_wr_data;
            wr_part <= 1'b0;
        end else if (wr_take) begin
            wr_full <= !wr_last_cyc;
            wr_part <= !wr_last_cyc;
        end
    end

    // Shared fabric bus and last-cycle strobe; high unless a final cycle is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_to_fabric <= '0;
            tw_last_n <= 1'b1;
        end else if (addr_take) begin
            if (addr_reuse) begin
                data_to_fabric <= last_addr;
            end else if (narrow) begin
                data_to_fabric <= {32'h0, addr_part ? cur_addr[63:32] : cur_addr[31:0]};
            end else begin
                data_to_fabric <= cur_addr;
            end
            tw_last_n <= !addr_final;
        end else if (wr_take) begin
            data_to_fabric <= narrow ? {32'h0, wr_part ? wr_word[63:32] : wr_word[31:0]} : wr_word;
            tw_last_n <= !(wr_fin && wr_last_cyc);
        end else begin
            tw_last_n <= 1'b1;
        end
    end

    // Full write slot: disconnect at once, or stretch with wait states while
    // burst pending is low; the limit keeps the PCI latency rule intact
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wstate <= WS_IDLE;
            wait_cnt <= 8'h0;
        end else begin
            case (wstate)
                WS_IDLE: begin
                    wait_cnt <= 8'h0;
                    if (pci_wr_valid && wr_full) begin
                        wstate <= burst_pend_n ? WS_DISC : WS_WAIT;
                    end
                end
                WS_WAIT: begin
                    wait_cnt <= wait_cnt + 1'b1;
                    if (!wr_full || !pci_wr_valid) begin
                        wstate <= WS_IDLE;
                    end else if (wait_cnt == 8'(MAX_WAIT - 1) || burst_pend_n) begin
                        wstate <= WS_DISC;
                    end
                end
                WS_DISC: begin
                    wstate <= WS_IDLE;
                end
                default: begin
                    wstate <= WS_IDLE;
                end
            endcase
        end
    end
    assign pci_wr_disconnect = (wstate == WS_DISC);

    // Read capture; narrow mode pairs low then high half into one word
    assign rd_push = !rd_data_en_n && (!narrow || rd_half);
    assign rd_din = narrow ? {data_fm_fabric[31:0], rd_lo} : data_fm_fabric;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_half <= 1'b0;
            rd_lo <= 32'h0;
        end else if (!rd_data_en_n && narrow) begin
            rd_half <= !rd_half;
            rd_lo <= data_fm_fabric[31:0];
        end else if (!narrow) begin
            rd_half <= 1'b0;
        end
    end

    // Read last marks only the cycle that completes a word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_last_n <= 1'b1;
        end else begin
            rd_last_n <= !(pci_rd_final && !rd_data_en_n && (!narrow || rd_half));
        end
    end

    // PCI transfer starts once hold is released or the FIFO has filled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_started <= 1'b0;
        end else if (!pci_rd_req) begin
            rd_started <= 1'b0;
        end else if (rd_hold_n || !rd_flags.full_n) begin
            rd_started <= 1'b1;
        end
    end
    assign pci_rd_valid = rd_started && rd_flags.empty_n;

    // Target read data FIFO; a push while full is dropped and flagged
    tfh_rd_fifo #(
        .WIDTH(DW),
        .DEPTH(DEPTH),
        .AFREE(`TFH_AFULL_FREE)
    ) u_tfh_rd_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .push(rd_push),
        .din(rd_din),
        .pop(pci_rd_valid && pci_rd_take),
        .dout(pci_rd_data),
        .count(rd_count),
        .flags(rd_flags)
    );
    assign rd_fifo_full_n = rd_flags.full_n;
    assign rd_fifo_almost_full_n = rd_flags.afull_n;
    assign rd_fifo_empty_n = rd_flags.empty_n;

    property p_addr_last;
        addr_take && !addr_reuse && !narrow |=> !tw_last_n && (data_to_fabric == $past(cur_addr));
    endproperty
    a_addr_last: assert property (p_addr_last) else $error("wide address portion not marked last");
    property p_reuse;
        addr_take && addr_reuse |=> !tw_last_n && target_req_n && (data_to_fabric == last_addr);
    endproperty
    a_reuse: assert property (p_reuse) else $error("reuse entry did not end at once");
    property p_wr_last;
        wr_take && wr_fin && !narrow |=> !tw_last_n ##1 tw_last_n || !wr_data_en_n;
    endproperty
    a_wr_last: assert property (p_wr_last) else $error("final write word not marked last");
    property p_half;
        (addr_take || wr_take) && narrow && !addr_final && !wr_part |=> tw_last_n;
    endproperty
    a_half: assert property (p_half) else $error("last marked on a first half");
    property p_wait;
        wstate == WS_IDLE && pci_wr_valid && wr_full && !burst_pend_n ##1 !burst_pend_n
        |-> !pci_wr_disconnect ##1 !pci_wr_disconnect;
    endproperty
    a_wait: assert property (p_wait) else $error("disconnect without wait states");
    property p_disc;
        wstate == WS_IDLE && pci_wr_valid && wr_full && burst_pend_n |=> pci_wr_disconnect;
    endproperty
    a_disc: assert property (p_disc) else $error("no immediate disconnect");
    property p_capture;
        !rd_data_en_n && !narrow && rd_flags.full_n && !(pci_rd_valid && pci_rd_take)
        |=> rd_count == $past(rd_count) + 1'b1;
    endproperty
    a_capture: assert property (p_capture) else $error("fabric read data not captured");
    property p_hold;
        pci_rd_req && !rd_started && !rd_hold_n && rd_flags.full_n |=> !pci_rd_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("read transfer began under hold");
    property p_rd_last;
        pci_rd_final && !rd_data_en_n && !narrow |=> !rd_last_n;
    endproperty
    a_rd_last: assert property (p_rd_last) else $error("final read data not marked");

    c_wait_disc: cover property (wstate == WS_WAIT ##1 wstate == WS_WAIT ##[1:300] pci_wr_disconnect);
    c_rd_full_start: cover property (!rd_hold_n && !rd_flags.full_n ##1 rd_started);
    c_two_part_addr: cover property (addr_take && !addr_final ##[1:20] addr_take && addr_final);
endmodule
`default_nettype wire

// [tfh_regs.svh]
// Register offsets, field positions, reset values and counts of the target FIFO handshake block
`ifndef TFH_REGS_SVH
`define TFH_REGS_SVH
`define TFH_CTRL_OFS 8'h00
`define TFH_STATUS_OFS 8'h04
`define TFH_IRQ_STAT_OFS 8'h08
`define TFH_IRQ_MASK_OFS 8'h0c
`define TFH_ADDR_LO_OFS 8'h10
`define TFH_ADDR_HI_OFS 8'h14
`define TFH_CTRL_NARROW_BIT 0
`define TFH_CTRL_RST 1'b0
`define TFH_IRQ_OVF_BIT 0
`define TFH_IRQ_DISC_BIT 1
`define TFH_IRQ_ADDR_BIT 2
`define TFH_IRQ_W 3
`define TFH_IRQ_RST 3'h0
`define TFH_ST_FULL_BIT 5
`define TFH_ST_REQ_BIT 8
`define TFH_FIFO_WIDTH 64
`define TFH_FIFO_DEPTH 16
`define TFH_AFULL_FREE 4
`define TFH_MAX_WAIT 8
`endif

// [tfh_pkg.sv]
// Types shared by the target FIFO handshake block
package tfh_pkg;
    // Write-side wait-state controller, one-hot
    typedef enum logic [2:0] {
        WS_IDLE = 3'b001,
        WS_WAIT = 3'b010,
        WS_DISC = 3'b100
    } tfh_wstate_type;
    // Read FIFO status flags, all active low
    typedef struct packed {
        logic full_n;
        logic afull_n;
        logic empty_n;
    } tfh_flags_type;
    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } tfh_ahb_type;
endpackage

// [tfh_rd_fifo.sv]
// Target read data FIFO with full, almost-full and empty flags
`timescale 1ns/10ps
`default_nettype none
`include "tfh_regs.svh"
module tfh_rd_fifo import tfh_pkg::*; #(
    parameter int WIDTH = `TFH_FIFO_WIDTH,
    parameter int DEPTH = `TFH_FIFO_DEPTH,
    parameter int AFREE = `TFH_AFULL_FREE
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic push, // Write request
    input wire logic [WIDTH-1:0] din, // Write data
    input wire logic pop, // Read request
    output logic [WIDTH-1:0] dout, // Head word
    output logic [$clog2(DEPTH+1)-1:0] count, // Words held
    output tfh_flags_type flags // Status flags
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] AF_CNT = CW'(DEPTH - AFREE);

    // Pointers wrap naturally, so depth must be a power of two
    generate
        if (DEPTH < AFREE + 2 || (1 << AW) != DEPTH) begin : g_chk
            $error("tfh_rd_fifo: DEPTH must be a power of two above AFREE+1");
        end
    endgenerate

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wptr; // Write pointer
    logic [AW-1:0] rptr; // Read pointer
    logic do_push; // Accepted write
    logic do_pop; // Accepted read

    // A write into a full FIFO is dropped, never overwrites
    assign do_push = push && (count != FULL_CNT);
    assign do_pop = pop && (count != '0);
    assign dout = mem[rptr];

    // Storage write
    always_ff @(posedge hclk) begin
        if (do_push) begin
            mem[wptr] <= din;
        end
    end

    // Pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            wptr <= wptr + AW'(do_push);
            rptr <= rptr + AW'(do_pop);
        end
    end

    // Fill level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (do_push && !do_pop) begin
            count <= count + 1'b1;
        end else if (do_pop && !do_push) begin
            count <= count - 1'b1;
        end
    end

    // Flags decode the registered level, so they move on the clock edge
    assign flags.full_n = (count != FULL_CNT);
    assign flags.afull_n = (count < AF_CNT);
    assign flags.empty_n = (count != '0);

    property p_full_hold;
        (count == FULL_CNT) && !pop |=> (count == FULL_CNT) && !flags.full_n;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag or level lost while full");
    property p_afull_edge;
        (count == AF_CNT - 1) && push && !pop |=> !flags.afull_n && flags.full_n;
    endproperty
    a_afull_edge: assert property (p_afull_edge) else $error("almost full not set at four free");
    property p_empty_rise;
        $rose(flags.empty_n) |-> $past(push) && (count == 1);
    endproperty
    a_empty_rise: assert property (p_empty_rise) else $error("empty flag left without a write");
endmodule
`default_nettype wire

// [tfh_fabric_model.sv]
// User target fabric model: takes addresses and fills the read FIFO
`timescale 1ns/10ps
`default_nettype none
module tfh_fabric_model #(
    parameter int LIMIT = 16
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic target_req_n, // Request pending, low
    input wire logic fill, // Bench asks for a read burst
    output logic addr_en_n, // Address enable, low
    output logic rd_data_en_n, // Read data enable, low
    output logic rd_hold_n, // Hold PCI read start, low
    output logic [63:0] data_fm_fabric // Read data, also the address
);
    logic [4:0] n; // Words pushed so far
    logic [4:0] n_next; // Count after this edge
    assign n_next = n + {4'h0, !rd_data_en_n};
    // All moves land just after the edge, as fabric registers would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_en_n <= 1'b1;
            rd_data_en_n <= 1'b1;
            rd_hold_n <= 1'b1;
            n <= 5'h0;
            data_fm_fabric <= 64'h1000;
        end else begin
            addr_en_n <= !(addr_en_n && !target_req_n); // Alternate so one request is taken once
            n <= n_next;
            data_fm_fabric <= data_fm_fabric + (rd_data_en_n ? 64'h0 : 64'h4);
            // Own count stops pushes, the flags lag one cycle
            rd_data_en_n <= !(fill && n_next < LIMIT);
            rd_hold_n <= !(fill && n_next < LIMIT); // Held through the fill
        end
    end
endmodule
`default_nettype wire

// [tfh_target_core_bench.sv]
// Self-checking bench of the target FIFO handshake block
`timescale 1ns/10ps
`default_nettype none
`include "tfh_regs.svh"
module tfh_target_core_bench;
    localparam logic [63:0] A = 64'h0123456789abcdef;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, irq, fill = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic av = 1'b0, reuse = 1'b0, wv = 1'b0, take = 1'b0, wen_n = 1'b1, bp_n = 1'b1, rreq = 1'b0, rfin = 1'b0;
    logic aen_n, den_n, hold_n, treq_n, tl_n, fl_n, af_n, em_n, disc, rv, rl_n;
    logic [63:0] pa = 64'h0, wd = 64'h0, dfm, dtf, rdat, seen;
    int n_mismatch = 0, checks_done = 0, i;
    always #20 hclk = ~hclk;
    // Keep what stood on the fabric bus while the last strobe was low
    always @(posedge hclk) if (tl_n === 1'b0) seen <= dtf;
    tfh_target_core #(.MAX_WAIT(3)) u_tfh_target_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .irq(irq), .pci_addr_valid(av), .pci_addr(pa),
        .pci_addr_reuse(reuse), .pci_addr_ready(), .pci_wr_valid(wv), .pci_wr_data(wd), .pci_wr_final(1'b1),
        .pci_wr_ready(), .pci_wr_disconnect(disc), .pci_rd_req(rreq), .pci_rd_final(rfin), .pci_rd_take(take),
        .pci_rd_valid(rv), .pci_rd_data(rdat), .target_req_n(treq_n), .addr_en_n(aen_n), .wr_data_en_n(wen_n),
        .data_to_fabric(dtf), .tw_last_n(tl_n), .wr_empty_n(), .burst_pend_n(bp_n), .data_fm_fabric(dfm),
        .rd_data_en_n(den_n), .rd_fifo_full_n(fl_n), .rd_fifo_almost_full_n(af_n), .rd_fifo_empty_n(em_n),
        .rd_hold_n(hold_n), .rd_last_n(rl_n));
    tfh_fabric_model u_tfh_fabric_model (.hclk(hclk), .hresetn(hresetn), .target_req_n(treq_n), .fill(fill),
        .addr_en_n(aen_n), .rd_data_en_n(den_n), .rd_hold_n(hold_n), .data_fm_fabric(dfm));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One AHB single word transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("flags", 3'h6, {fl_n, af_n, em_n});
        // Fresh address, then a reuse entry that must repeat it
        for (int r = 0; r < 2; r++) begin
            @(posedge hclk);
            av <= 1'b1;
            reuse <= r[0];
            pa <= r ? 64'h0 : A;
            @(posedge hclk);
            av <= 1'b0;
            @(negedge hclk);
            chk("target_req_n", 1'b0, treq_n);
            repeat (4) @(posedge hclk);
            @(negedge hclk);
            chk("last address", A, seen);
            seen = 64'h0;
        end
        $display("Address test done");
        // Second word meets a full slot: wait states, then disconnect
        @(posedge hclk);
        wv <= 1'b1;
        wd <= 64'hfeedc0de00c0ffee;
        bp_n <= 1'b0;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (disc !== 1'b1 && i < 20);
        chk("wait cycles", 1'b1, i >= 4 && i <= 6);
        wv <= 1'b0;
        bp_n <= 1'b1;
        @(posedge hclk);
        wen_n <= 1'b0;
        @(posedge hclk);
        wen_n <= 1'b1;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("last write", wd, seen);
        // Disconnect event: unmask, raise, clear
        @(posedge hclk);
        ahb(1'b1, `TFH_IRQ_MASK_OFS, 32'h2);
        @(negedge hclk);
        chk("irq raised", 1'b1, irq);
        @(posedge hclk);
        ahb(1'b1, `TFH_IRQ_STAT_OFS, 32'h2);
        @(negedge hclk);
        chk("irq cleared", 1'b0, irq);
        // Narrow mode: low half first, then the high half marked last
        @(posedge hclk);
        ahb(1'b1, `TFH_CTRL_OFS, 32'h1);
        @(posedge hclk);
        ahb(1'b0, `TFH_CTRL_OFS, 32'h0);
        chk("narrow mode", 32'h1, rd);
        av <= 1'b1;
        reuse <= 1'b0;
        pa <= A;
        @(posedge hclk);
        av <= 1'b0;
        repeat (6) @(posedge hclk);
        @(negedge hclk);
        chk("narrow last", {32'h0, A[63:32]}, seen);
        @(posedge hclk);
        ahb(1'b1, `TFH_CTRL_OFS, 32'h0);
        @(posedge hclk);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("Write test done");
        // Burst read held while fabric fills, released once full
        @(posedge hclk);
        fill <= 1'b1;
        // Request only once the hold stands, or the start slips through
        @(posedge hclk);
        rreq <= 1'b1;
        rfin <= 1'b1;
        repeat (6) @(posedge hclk);
        @(negedge hclk);
        chk("read held", 1'b0, rv);
        chk("read last", 1'b0, rl_n);
        repeat (16) @(posedge hclk);
        @(negedge hclk);
        chk("flags full", 3'h1, {fl_n, af_n, em_n});
        chk("read last", 1'b1, rl_n);
        for (i = 0; i < 16; i++) begin
            chk("read data", 64'h1000 + 4 * i, rdat);
            chk("almost full", (16 - i) < 12, af_n);
            chk("read valid", 1'b1, rv);
            @(posedge hclk);
            take <= 1'b1;
            @(posedge hclk);
            take <= 1'b0;
            @(posedge hclk);
            @(negedge hclk);
        end
        chk("empty", 1'b0, em_n);
        $display("Read test done");
        stop_test();
    end
    // Whole run is under two hundred cycles
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
